// *** verilog/rsr_device.sv ***
// register end: reset source flags, slow oscillator control, peripheral
// reset lines
// assumes a simple synchronous register port on clk; reset sources on the
// link are pulses on the same clock, so nothing is synchronised here
`timescale 1ns/1ps
module rsr_device (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic por_arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	rsr_if.dev link
);
	import rsr_pkg::*;

	logic [31:0] flags_r;
	logic [31:0] flags_nxt;
	logic osc_en_r;
	logic [31:0] prst_r;
	logic [31:0] rdata_r;
	logic rvalid_r;
	logic [31:0] wmask;
	logic wr_src;
	logic wr_prst;
	logic clr_req;
	logic [31:0] evt_word;
	logic [31:0] src_view;

	// write decode, byte lanes honoured
	assign wmask = rsr_be_mask(reg_be);
	assign wr_src = reg_wr && (reg_addr == RSR_OFS_SRC);
	assign wr_prst = reg_wr && (reg_addr == RSR_OFS_PRST);
	assign clr_req = wr_src && wmask[RSR_BIT_CLR] && reg_wdata[RSR_BIT_CLR];

	// source pulses placed at their flag bits
	assign evt_word = rsr_evt_word(link.evt) & RSR_FLAG_MASK;

	// clear first, then set, so a pulse in the clear cycle survives
	always_comb begin
		flags_nxt = flags_r;
		if (clr_req) begin
			flags_nxt = flags_r & ~RSR_FLAG_MASK;
		end
		flags_nxt = flags_nxt | evt_word;
	end

	// flags live on the power reset only; a system reset keeps them,
	// which is why they are read after the reset that set them
	always_ff @(posedge clk or negedge por_arst_n) begin
		if (!por_arst_n) begin
			flags_r <= RSR_SRC_RESET & RSR_FLAG_MASK;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// oscillator enable, cleared by system reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			osc_en_r <= RSR_OSCEN_RESET;
		end else if (wr_src && wmask[RSR_BIT_OSCEN]) begin
			osc_en_r <= reg_wdata[RSR_BIT_OSCEN];
		end
	end

	// peripheral reset bits; reserved bits never store
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prst_r <= RSR_PRST_RESET;
		end else if (wr_prst) begin
			prst_r <= (prst_r & ~wmask) |
				(reg_wdata & wmask & RSR_PRST_MASK);
		end
	end

	// read image of the source register; clear bit acts on write and
	// reads as zero, stable bit is live from the oscillator
	always_comb begin
		src_view = flags_r;
		src_view[RSR_BIT_OSCEN] = osc_en_r;
		src_view[RSR_BIT_STB] = link.slow_osc_stable;
	end

	// registered read data, one cycle after the strobe; unmapped reads 0
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 32'h00000000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_rd;
			if (reg_rd) begin
				unique case (reg_addr)
					RSR_OFS_SRC: begin
						rdata_r <= src_view;
					end
					RSR_OFS_PRST: begin
						rdata_r <= prst_r;
					end
					default: begin
						rdata_r <= 32'h00000000;
					end
				endcase
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;

	// lines toward the far side, straight from the flops
	assign link.slow_osc_enable = osc_en_r;
	assign link.touch_unit_reset = prst_r[RSR_BIT_TSI];

	generate
		for (genvar p = 0; p < RSR_NPORT; p++) begin : g_port
			assign link.port_reset[p] = prst_r[RSR_PORT_BIT[p]];
		end
	endgenerate

endmodule

// *** verilog/rsr_pkg.sv ***
// constants, field layout and decode helpers for the reset source block
// assumes one 100 MHz clock shared by both ends and by the register port
package rsr_pkg;

	// register byte offsets
	localparam logic [7:0] RSR_OFS_SRC = 8'h24;
	localparam logic [7:0] RSR_OFS_PRST = 8'h28;

	// reset source register layout
	localparam int RSR_BIT_LP = 31;
	localparam int RSR_BIT_WWDG = 30;
	localparam int RSR_BIT_IWDG = 29;
	localparam int RSR_BIT_SW = 28;
	localparam int RSR_BIT_POR = 27;
	localparam int RSR_BIT_EP = 26;
	localparam int RSR_BIT_OBL = 25;
	localparam int RSR_BIT_CLR = 24;
	localparam int RSR_BIT_CORE = 23;
	localparam int RSR_BIT_STB = 1;
	localparam int RSR_BIT_OSCEN = 0;
	localparam logic [31:0] RSR_FLAG_MASK = 32'hfe800000;
	localparam logic [31:0] RSR_SRC_RESET = 32'h0c000000;
	localparam logic RSR_OSCEN_RESET = 1'b0;

	// peripheral reset register layout
	localparam int RSR_BIT_TSI = 24;
	localparam int RSR_NPORT = 5;
	localparam logic [31:0] RSR_PRST_MASK = 32'h015e0000;
	localparam logic [31:0] RSR_PRST_RESET = 32'h00000000;

	// event vector positions, one per reset source
	localparam int RSR_NEVT = 8;
	localparam int RSR_EVT_LP = 0;
	localparam int RSR_EVT_WWDG = 1;
	localparam int RSR_EVT_IWDG = 2;
	localparam int RSR_EVT_SW = 3;
	localparam int RSR_EVT_POR = 4;
	localparam int RSR_EVT_EP = 5;
	localparam int RSR_EVT_OBL = 6;
	localparam int RSR_EVT_CORE = 7;

	// slow oscillator settle time, only modelled by the far end
	localparam int RSR_CLK_PERIOD_NS = 10;
	localparam int RSR_OSC_SETTLE_NS = 160;
	localparam int RSR_OSC_SETTLE_CYC =
		(RSR_OSC_SETTLE_NS + RSR_CLK_PERIOD_NS - 1) / RSR_CLK_PERIOD_NS;
	localparam int RSR_CNT_W = 8;

	// port index order on the link: a, b, c, d, f
	typedef int rsr_bitpos_t [RSR_NPORT];
	localparam rsr_bitpos_t RSR_PORT_BIT = '{17, 18, 19, 20, 22};

	// place each source event at its flag position
	function automatic logic [31:0] rsr_evt_word(input logic [7:0] e);
		logic [31:0] w;
		w = 32'h00000000;
		w[RSR_BIT_LP] = e[RSR_EVT_LP];
		w[RSR_BIT_WWDG] = e[RSR_EVT_WWDG];
		w[RSR_BIT_IWDG] = e[RSR_EVT_IWDG];
		w[RSR_BIT_SW] = e[RSR_EVT_SW];
		w[RSR_BIT_POR] = e[RSR_EVT_POR];
		w[RSR_BIT_EP] = e[RSR_EVT_EP];
		w[RSR_BIT_OBL] = e[RSR_EVT_OBL];
		w[RSR_BIT_CORE] = e[RSR_EVT_CORE];
		return w;
	endfunction

	// widen byte enables to a bit mask
	function automatic logic [31:0] rsr_be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h00000000;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction

endpackage

// *** verilog/rsr_if.sv ***
// link between the reset source register block and the reset side logic
// assumes both ends run on the same clock; no clocking here
`timescale 1ns/1ps
interface rsr_if;
	import rsr_pkg::*;

	logic [RSR_NEVT-1:0] evt; // source requests one cycle late, high for as long as each is held
	logic slow_osc_enable;
	logic slow_osc_stable;
	logic touch_unit_reset;
	logic [RSR_NPORT-1:0] port_reset; // a, b, c, d, f

	modport dev (
		input evt,
		input slow_osc_stable,
		output slow_osc_enable,
		output touch_unit_reset,
		output port_reset
	);

	modport far (
		output evt,
		output slow_osc_stable,
		input slow_osc_enable,
		input touch_unit_reset,
		input port_reset
	);
endinterface

// *** verilog/rsr_far.sv ***
// reset side end: gathers source events, models the slow oscillator
// settling and hands the peripheral reset lines on
// assumes source requests come from logic on the same clock
`timescale 1ns/1ps
module rsr_far (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] src_req,
	output logic osc_running,
	output logic touch_rst,
	output logic [4:0] port_rst,
	rsr_if.far link
);
	import rsr_pkg::*;

	logic [RSR_NEVT-1:0] evt_r;
	logic [RSR_CNT_W-1:0] settle_r;
	logic stable_r;
	logic touch_r;
	logic [RSR_NPORT-1:0] port_r;

	// each request is registered onto the link one cycle later, and stays high for as long as the request is held
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			evt_r <= '0;
		end else begin
			evt_r <= src_req;
		end
	end

	// stable only after the settle time with enable held; drops on the first edge
	// after the enable goes, so a read in the very next cycle still sees ready
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			settle_r <= '0;
			stable_r <= 1'b0;
		end else if (!link.slow_osc_enable) begin
			settle_r <= '0;
			stable_r <= 1'b0;
		end else if (settle_r == RSR_CNT_W'(RSR_OSC_SETTLE_CYC - 1)) begin
			stable_r <= 1'b1;
		end else begin
			settle_r <= settle_r + RSR_CNT_W'(1);
		end
	end

	// peripheral resets held while their bits stay set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			touch_r <= 1'b0;
			port_r <= '0;
		end else begin
			touch_r <= link.touch_unit_reset;
			port_r <= link.port_reset;
		end
	end

	assign link.evt = evt_r;
	assign link.slow_osc_stable = stable_r;
	assign osc_running = stable_r;
	assign touch_rst = touch_r;
	assign port_rst = port_r;

endmodule

// *** sim/rsr_properties.sv ***
// link checks between the register end and the reset side end
// assumes one clock and an active-low system reset
`timescale 1ns/1ps
module rsr_properties (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic slow_osc_enable,
	input wire logic slow_osc_stable,
	input wire logic touch_unit_reset,
	input wire logic [4:0] port_reset
);
	import rsr_pkg::*;
	logic [7:0] en_cnt_r;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// cycles with enable high; saturates so long runs never wrap
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			en_cnt_r <= 8'h00;
		else if (!slow_osc_enable)
			en_cnt_r <= 8'h00;
		else if (en_cnt_r != 8'hff)
			en_cnt_r <= en_cnt_r + 8'h01;
	end
	a_lines_clear: assert property (
		$rose(arst_n) |-> port_reset == 5'h00 && !touch_unit_reset)
		else $error("peripheral reset line high after reset");
	a_osc_off_rst: assert property (
		$rose(arst_n) |-> !slow_osc_enable && !slow_osc_stable)
		else $error("oscillator on after reset");
	a_stable_early: assert property (
		slow_osc_enable && en_cnt_r < 8'(RSR_OSC_SETTLE_CYC) |->
		!slow_osc_stable)
		else $error("oscillator stable before settling");
	a_stable_late: assert property (
		en_cnt_r == 8'(RSR_OSC_SETTLE_CYC) |-> slow_osc_stable)
		else $error("oscillator never became stable");
	a_stable_off: assert property (
		!slow_osc_enable ##1 !slow_osc_enable |-> !slow_osc_stable)
		else $error("oscillator stable while disabled");
	// the ready flag must follow a dropped enable on the next edge
	a_stable_drop: assert property (
		$fell(slow_osc_enable) |=> !slow_osc_stable)
		else $error("oscillator stable after enable dropped");
endmodule

// *** sim/reset_source_and_ahb_reset_test.sv ***
// self-checking bench: both ends joined by the link
// assumes the register port answers reads one cycle later
`timescale 1ns/1ps
module reset_source_and_ahb_reset_test;
	import rsr_pkg::*;
	logic clk, arst_n, por_arst_n, reg_wr, reg_rd, reg_rvalid;
	logic osc_running, touch_rst;
	logic [7:0] reg_addr, src_req;
	logic [3:0] reg_be;
	logic [4:0] port_rst;
	logic [31:0] reg_wdata, reg_rdata, flags, d;
	logic [31:0] exp_q[$];
	int miscompares, n_compared, seed;
	int evt_bit[8] = '{31, 30, 29, 28, 27, 26, 25, 23};
	rsr_if link();
	rsr_device u_rsr_device(.clk(clk), .arst_n(arst_n),
		.por_arst_n(por_arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .link(link));
	rsr_far u_rsr_far(.clk(clk), .arst_n(arst_n), .src_req(src_req),
		.osc_running(osc_running), .touch_rst(touch_rst),
		.port_rst(port_rst), .link(link));
	rsr_properties u_rsr_properties(.clk(clk), .arst_n(arst_n),
		.slow_osc_enable(link.slow_osc_enable),
		.slow_osc_stable(link.slow_osc_stable),
		.touch_unit_reset(link.touch_unit_reset),
		.port_reset(link.port_reset));
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h not %h", $time, got, exp);
		end
	endtask
	// line outputs toward the peripherals and the oscillator
	task automatic compare_line(input logic [5:0] got, input logic [5:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: line %h not %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		// a read that never answered leaves its note behind
		if (exp_q.size() != 0)
			miscompares++;
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// called at a falling edge; a spare cycle keeps strobes apart
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] be);
		reg_addr = a;
		reg_wdata = v;
		reg_be = be;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		exp_q.push_back(exp);
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
	endtask
	// read answers are matched against the oldest note
	always @(negedge clk) begin
		if (reg_rvalid === 1'b1) begin
			if (exp_q.size() > 0) begin
				compare(reg_rdata, exp_q.pop_front());
			end else begin
				miscompares++;
				$display("wrong value at %0t: answer without a read", $time);
			end
		end
	end
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// the whole run needs well under 600 cycles
	initial begin
		#20000;
		miscompares++;
		close_out();
	end
	initial begin
		seed = 32'he6120353;
		{arst_n, por_arst_n, reg_wr, reg_rd} = 4'h0;
		{reg_addr, reg_be, reg_wdata, src_req} = 52'h0;
		repeat (5) @(negedge clk);
		arst_n = 1'b1;
		por_arst_n = 1'b1;
		@(negedge clk);
		rd(RSR_OFS_SRC, 32'h0c000000);
		rd(RSR_OFS_PRST, 32'h00000000);
		// one source at a time, flags pile up
		flags = 32'h0c000000;
		for (int i = 0; i < 8; i++) begin
			src_req[i] = 1'b1;
			@(negedge clk);
			src_req = 8'h00;
			repeat (2) @(negedge clk);
			flags[evt_bit[i]] = 1'b1;
			rd(RSR_OFS_SRC, flags);
		end
		wr(RSR_OFS_SRC, 32'h00000000, 4'hf);
		rd(RSR_OFS_SRC, flags);
		// event lands in the very cycle of the clear and must survive
		src_req = 8'h08;
		@(negedge clk);
		src_req = 8'h00;
		wr(RSR_OFS_SRC, 32'h01000000, 4'hf);
		rd(RSR_OFS_SRC, 32'h10000000);
		// bit 1 is read-only, so writing it changes nothing
		wr(RSR_OFS_SRC, 32'h00000003, 4'h1);
		rd(RSR_OFS_SRC, 32'h10000001);
		repeat (20) @(negedge clk);
		rd(RSR_OFS_SRC, 32'h10000003);
		compare_line({5'h0, osc_running}, 6'h01);
		wr(RSR_OFS_SRC, 32'h00000000, 4'h1);
		repeat (3) @(negedge clk);
		rd(RSR_OFS_SRC, 32'h10000000);
		// reserved bits written as zero, as software must
		repeat (6) begin
			d = $random(seed) & 32'h015e0000;
			wr(RSR_OFS_PRST, d, 4'hf);
			rd(RSR_OFS_PRST, d);
			compare_line({5'h0, touch_rst}, {5'h0, d[24]});
			compare_line({1'b0, port_rst}, {1'b0, d[22], d[20:17]});
		end
		wr(8'h2c, 32'hffffffff, 4'hf);
		rd(8'h2c, 32'h00000000);
		// system reset keeps the flags, drops everything else
		wr(RSR_OFS_PRST, 32'h015e0000, 4'hf);
		wr(RSR_OFS_SRC, 32'h00000001, 4'h1);
		arst_n = 1'b0;
		@(negedge clk);
		arst_n = 1'b1;
		@(negedge clk);
		rd(RSR_OFS_SRC, 32'h10000000);
		rd(RSR_OFS_PRST, 32'h00000000);
		por_arst_n = 1'b0;
		@(negedge clk);
		por_arst_n = 1'b1;
		@(negedge clk);
		rd(RSR_OFS_SRC, 32'h0c000000);
		close_out();
	end
endmodule
